// *** bench/gpe_pad_model.sv ***
// Purpose: Board-side model of the eight port pads.
// Assumes: Port drive overrides any board drive on the same pad.
// Notes:   An undriven, unpulled pad toggles every clock.
`timescale 1ns/1ps
// ==========================================================
// Pad model
module gpe_pad_model (
    input  wire logic       clk,
    input  wire logic [7:0] pin_out,
    input  wire logic [7:0] pin_oe_n,
    input  wire logic [7:0] pull_up,
    input  wire logic [7:0] pull_dn,
    input  wire logic [7:0] ext_en,
    input  wire logic [7:0] ext_val,
    output logic      [7:0] pad
);
    logic [7:0] float_q = 8'h5A;
    // A floating pad must never look like a steady level
    always_ff @(posedge clk) begin
        float_q <= ~float_q;
    end
    // Port drive first, then board drive, then pull device
    always_comb begin
        for (int i = 0; i < 8; i++) begin
            if (!pin_oe_n[i]) pad[i] = pin_out[i];
            else if (ext_en[i]) pad[i] = ext_val[i];
            else if (pull_up[i]) pad[i] = 1'b1;
            else if (pull_dn[i]) pad[i] = 1'b0;
            else pad[i] = float_q[i];
        end
    end
endmodule : gpe_pad_model

// *** bench/testbench.sv ***
// Purpose: Self-checking bench for the GPIO edge-interrupt port.
// Assumes: Register model and pad model in the bench.
// Notes:   Floating pad bits are masked out of read comparisons.
`timescale 1ns/1ps
// ==========================================================
// Bench top
module testbench
    import gpe_pkg::*;
;
    logic       clk, rst_n, wr, rd, ana, stop, waitm, rc_tick, rc_run, irq, wake;
    logic [3:0] addr;
    logic [7:0] wdata, rdata, pad, pin_out, oe_n, rdrv, pup, pdn, own, ext_en, ext_val, v, pol, drv;
    logic [7:0] m [0:15];
    int         n_fail, total_checks, len;

    // Bus clock, 50 ns
    always #25 clk = ~clk;

    gpe_port dut (.REF_CLK(clk), .RSTN(rst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata),
        .PIN_IN(pad), .PIN_OUT(pin_out), .PIN_OE_N(oe_n), .PIN_RDRV(rdrv), .PIN_PULLUP(pup), .PIN_PULLDN(pdn),
        .PERIPH_OWN(own), .ANALOG_EN(ana), .STOP_MODE(stop), .WAIT_MODE(waitm), .RC_TICK(rc_tick),
        .RC_OSC_RUN(rc_run), .PORT_IRQ(irq), .WAKEUP(wake));
    gpe_pad_model board (.clk(clk), .pin_out(pin_out), .pin_oe_n(oe_n), .pull_up(pup), .pull_dn(pdn),
        .ext_en(ext_en), .ext_val(ext_val), .pad(pad));

    // ==========================================================
    // Model
    function automatic logic [7:0] pad_e();
        logic [7:0] d;
        d = m[2] & ~{8{ana}};
        return (d & m[0]) | (~d & ext_en & ext_val) | (~d & ~ext_en & ~m[2] & m[4] & ~m[5]);
    endfunction : pad_e

    function automatic logic [7:0] stat_e();
        logic i_e, r_e, w_e;
        i_e = |(m[7] & m[6]);
        r_e = stop & |(m[6] & ~m[7]);
        w_e = ((stop | waitm) & i_e) | (stop & ~ana & |(m[6] & ~m[7] & ~(pad_e() ^ m[5])));
        return {5'h00, w_e, r_e, i_e};
    endfunction : stat_e

    function automatic logic [7:0] exp_rd(input logic [3:0] a);
        logic [7:0] din;
        din = ana ? 8'hFF : (pad_e() & (m[8] | m[2])) | ~(m[8] | m[2]);
        if (a == ADDR_DATA) return (m[2] & m[0]) | (~m[2] & din);
        if (a == ADDR_INPUT) return din;
        if (a == ADDR_STAT) return stat_e();
        return (a <= ADDR_DIEN) ? m[a] : 8'h00;
    endfunction : exp_rd

    // Bits whose pad has neither driver nor pull
    function automatic logic [7:0] unk(input logic [3:0] a);
        logic [7:0] d, ud;
        d  = m[2] & ~{8{ana}};
        ud = ~(d | ext_en | (~m[2] & m[4])) & (m[8] | m[2]) & ~{8{ana}};
        if (a == ADDR_INPUT) return ud;
        return (a == ADDR_DATA) ? (ud & ~m[2]) : 8'h00;
    endfunction : unk

    // ==========================================================
    // Bus tasks and checks
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        total_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("FAIL %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic wr_reg(input logic [3:0] a, input logic [7:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr <= 1'b0;
        if (a == ADDR_DIR) m[2] = (d & ~own) | (m[2] & own);
        else if (a == ADDR_FLAG) m[7] = m[7] & ~d;
        else if (a != ADDR_INPUT && a <= ADDR_DIEN) m[a] = d;
        #1;
    endtask : wr_reg

    task automatic rd_reg(input logic [3:0] a, output logic [7:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1 d = rdata;
    endtask : rd_reg

    task automatic chk_regs();
        for (int a = 0; a < 16; a++) begin
            rd_reg(a[3:0], v);
            chk($sformatf("reg%0d", a), v & ~unk(a[3:0]), exp_rd(a[3:0]) & ~unk(a[3:0]));
        end
    endtask : chk_regs

    task automatic rc_pulses(input int n);
        repeat (n) begin
            repeat (4) @(posedge clk);
            rc_tick <= 1'b1;
            repeat (4) @(posedge clk);
            rc_tick <= 1'b0;
        end
    endtask : rc_pulses

    task automatic test_done();
        $display("checks %0d mismatches %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : test_done

    // ==========================================================
    // Main sequence
    // Offsets for the random writes; read-only and unmapped ones must be ignored
    localparam logic [3:0] ADDR_LIST [9] = '{ADDR_DATA, ADDR_INPUT, ADDR_DIR, ADDR_RDRV, ADDR_PULLEN,
                                             ADDR_POL, ADDR_DIEN, ADDR_STAT, 4'hC};

    // Reset, random configurations, pulse filtering, then stop mode
    initial begin
        {clk, rst_n, wr, rd, ana, stop, waitm, rc_tick, addr, wdata, own, ext_val} = '0;
        ext_en = 8'hFF;
        n_fail = 0;
        total_checks = 0;
        foreach (m[i]) m[i] = 8'h00;
        m[8] = RST_DIEN;
        void'($urandom(32'h23dd));
        repeat (12) @(posedge clk);
        chk("oe_n rst", oe_n, 8'hFF);
        chk("pads rst", pup | pdn | rdrv | pin_out, 8'h00);
        rst_n <= 1'b1;
        chk_regs();
        // Random configurations, peripheral ownership and analog takeover
        for (int k = 0; k < 8; k++) begin
            own     <= 8'($urandom());
            ana     <= ($urandom() % 3 == 0);
            ext_en  <= 8'($urandom());
            ext_val <= 8'($urandom());
            foreach (ADDR_LIST[j]) wr_reg(ADDR_LIST[j], 8'($urandom()));
            repeat (4) @(posedge clk);
            drv = m[2] & ~{8{ana}};
            chk("oe_n", oe_n, ~drv);
            chk("out", pin_out, m[0]);
            chk("rdrv", rdrv, drv & m[3]);
            chk("pullup", pup, ~m[2] & m[4] & ~m[5]);
            chk("pulldn", pdn, ~m[2] & m[4] & m[5]);
            chk_regs();
        end
        // Reset in mid-run must act without a clock edge
        own <= 8'h00;
        ana <= 1'b0;
        wr_reg(ADDR_DIR, 8'hFF);
        #10 rst_n = 1'b0;
        #2 chk("oe_n async", oe_n, 8'hFF);
        foreach (m[i]) m[i] = 8'h00;
        m[8] = RST_DIEN;
        ext_en = 8'hFF;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        // Pulse of 3 ignored, 4 accepted, none while disabled
        for (int p = 0; p < 8; p++) begin
            for (int c = 0; c < 3; c++) begin
                pol = 8'($urandom());
                len = (c == 0) ? 3 : 4;
                ext_val <= ~pol;
                waitm <= 1'($urandom());
                wr_reg(ADDR_POL, pol);
                wr_reg(ADDR_IEN, (c == 2) ? 8'h00 : 8'h01 << p);
                repeat (8) @(posedge clk);
                ext_val[p] <= pol[p];
                repeat (len) @(posedge clk);
                ext_val[p] <= ~pol[p];
                repeat (12) @(posedge clk);
                if (c == 1) m[7][p] = 1'b1;
                chk("irq", irq, |(m[7] & m[6]));
                chk("wake", wake, waitm & |(m[7] & m[6]));
                rd_reg(ADDR_FLAG, v);
                chk("flags", v, m[7]);
                rd_reg(ADDR_STAT, v);
                chk("stat", v, stat_e());
                wr_reg(ADDR_FLAG, 8'hFF);
                chk("irq clr", irq, 1'b0);
                wr_reg(ADDR_IEN, 8'h00);
            end
        end
        // Stop mode: RC-tick sampling and raw wake path
        waitm   <= 1'b0;
        ext_val <= 8'h00;
        wr_reg(ADDR_POL, 8'h01);
        wr_reg(ADDR_IEN, 8'h01);
        stop <= 1'b1;
        repeat (2) @(posedge clk);
        #1 chk("rc run", rc_run, 1'b1);
        chk("wake idle", wake, 1'b0);
        rc_pulses(6);
        ext_val[0] <= 1'b1;
        repeat (10) @(posedge clk);
        #1 chk("wake raw", wake, 1'b1);
        chk("no bus sampling", irq, 1'b0);
        rc_pulses(6);
        m[7] = 8'h01;
        #1 chk("irq stop", irq, 1'b1);
        chk("rc halt", rc_run, 1'b0);
        test_done();
    end

    // Watchdog against a hang
    initial begin
        #(50 * 20000);
        n_fail++;
        test_done();
    end
endmodule : testbench

// *** common/gpe_pkg.sv ***
// Purpose: Shared constants and types for the GPIO edge-interrupt port.
// Assumes: One eight-pin interrupt-capable port, 8-bit register port.
// Notes:   Offsets are word indices on the plain register port.

// ==========================================================
// Package
package gpe_pkg;

    // Port width
    localparam int         NPIN = 8;

    // Register offsets
    localparam logic [3:0] ADDR_DATA   = 4'h0;
    localparam logic [3:0] ADDR_INPUT  = 4'h1;
    localparam logic [3:0] ADDR_DIR    = 4'h2;
    localparam logic [3:0] ADDR_RDRV   = 4'h3;
    localparam logic [3:0] ADDR_PULLEN = 4'h4;
    localparam logic [3:0] ADDR_POL    = 4'h5;
    localparam logic [3:0] ADDR_IEN    = 4'h6;
    localparam logic [3:0] ADDR_FLAG   = 4'h7;
    localparam logic [3:0] ADDR_DIEN   = 4'h8;
    localparam logic [3:0] ADDR_STAT   = 4'h9;

    // Values after reset
    localparam logic [7:0] RST_ZERO = 8'h00;
    localparam logic [7:0] RST_DIEN = 8'hFF;

    // Status bit positions
    localparam int         STAT_IRQ  = 0;
    localparam int         STAT_RC   = 1;
    localparam int         STAT_WAKE = 2;

    // Glitch filter: consecutive samples per level
    localparam logic [2:0] FILT_CNT = 3'h4;

    // Stop-mode pulse limits, set by the RC oscillator period
    localparam int         STOP_IGNORE_NS = 3200;
    localparam int         STOP_VALID_NS  = 10000;

    typedef logic [7:0] gpe_byte_t;

    // Per-pin configuration, one bit per pin in each field
    typedef struct packed {
        gpe_byte_t dir;
        gpe_byte_t out;
        gpe_byte_t rdrv;
        gpe_byte_t pull_en;
        gpe_byte_t pol;
        gpe_byte_t irq_en;
        gpe_byte_t dien;
    } gpe_cfg_s;

endpackage : gpe_pkg

// *** rtl/gpe_edge_filter.sv ***
// Purpose: Per-pin glitch filter that qualifies one edge.
// Assumes: act is already polarity-corrected, smp marks a sample.
// Notes:   A short return to passive does not lose the passive history.

`timescale 1ns/1ps

// ==========================================================
// Edge filter
module gpe_edge_filter
    import gpe_pkg::*;
(
    input  wire logic clk,
    input  wire logic rst_n,
    input  wire logic smp,
    input  wire logic act,
    input  wire logic arm,
    output logic      edge_o
);

    logic [2:0] pas_q;
    logic [2:0] acc_q;
    logic       hit;

    // Fourth active sample after four passive ones
    assign hit = smp && act && (pas_q == FILT_CNT) && (acc_q == FILT_CNT - 3'h1); // [RL13]

    // Passive run counter, saturates at the threshold
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            pas_q <= 3'h0;
        end else if (smp) begin
            if (hit) begin
                pas_q <= 3'h0;
            end else if (!act) begin
                pas_q <= (pas_q == FILT_CNT) ? pas_q : pas_q + 3'h1;
            end else if (pas_q != FILT_CNT) begin
                pas_q <= 3'h0;
            end
        end
    end

    // Active run counter; three samples never reach a hit
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            acc_q <= 3'h0;
        end else if (smp) begin
            if (!act || hit || pas_q != FILT_CNT) begin
                acc_q <= 3'h0; // [RL14]
            end else begin
                acc_q <= acc_q + 3'h1;
            end
        end
    end

    // Registered edge, only while the pin interrupt is on
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            edge_o <= 1'b0;
        end else begin
            edge_o <= hit && arm;
        end
    end

    default clocking fc @(posedge clk); endclocking
    default disable iff (!rst_n);

    fire_cause_a: assert property ( // [RL13]
        edge_o |-> $past(smp && act && acc_q == FILT_CNT - 3'h1 && arm))
        else $error("edge without four active samples");

    one_shot_a: assert property ( // [RL14]
        edge_o |=> !edge_o)
        else $error("edge repeated back to back");

endmodule : gpe_edge_filter

// *** rtl/gpe_port.sv ***
// Purpose: Eight-pin GPIO port with per-pin edge interrupts and wake-up.
// Assumes: Register port on REF_CLK; pad levels arrive asynchronously.
// Notes:   Stop-mode sampling runs from the RC tick, not the bus clock.

`timescale 1ns/1ps

// ==========================================================
// Top module
// Behaviour
// RL1: Polarity bit picks interrupt edge and also pull-up versus pull-down.
// RL2: With interrupt on, polarity 0 means falling edge, 1 rising edge.
// RL3: Input with pull enabled: polarity 0 pulls up, 1 down; outputs never pull.
// RL4: Output pin drives stored bit, reduced drive when its drive bit is 1.
// RL5: Only this eight-pin port has pin interrupts; other ports have none.
// RL6: Analog module enabled: digital drivers off and digital inputs read 1.
// RL7: After reset every pin is a general-purpose input.
// RL8: All registers are set or cleared by reset asynchronously.
// RL9: Eight pins, each with own enable and polarity, share one interrupt.
// RL10: Edge interrupts work on inputs with digital buffer enabled, or outputs.
// RL11: Interrupt request is high while any flag and its enable are set.
// RL12: Enabled pin edge interrupts wake the processor from stop and wait.
// RL13: Valid edge needs four passive samples then four active samples.
// RL14: Run/wait: three clocks ignored, four accepted; stop: RC-timed limits.
// RL15: Filters sample every bus clock in run and wait modes.
// RL16: In stop mode filters sample on the local RC oscillator instead.
// RL17: RC oscillator runs only while some enabled pin has its flag clear.
// RL18: An asynchronous path lets pin edges wake the part with clocks stopped.
// RL19: Direction 0 input, 1 output; writes ignored while a peripheral owns pin.
// RL20: Data read returns pin level for inputs, stored bit for outputs.
// RL21: Reads may lag a direction change by up to two bus cycles.
// RL22: Flag sets on filtered edge of selected polarity; software writes 1 to clear.
// RL23: Pin inputs pass a two-stage synchroniser before reads and edge detection.
module gpe_port
    import gpe_pkg::*;
(
    input  wire logic       REF_CLK,
    input  wire logic       RSTN,
    input  wire logic [3:0] ADDR,
    input  wire logic [7:0] WDATA,
    input  wire logic       WR,
    input  wire logic       RD,
    output logic      [7:0] RDATA,
    input  wire logic [7:0] PIN_IN,
    output logic      [7:0] PIN_OUT,
    output logic      [7:0] PIN_OE_N,
    output logic      [7:0] PIN_RDRV,
    output logic      [7:0] PIN_PULLUP,
    output logic      [7:0] PIN_PULLDN,
    input  wire logic [7:0] PERIPH_OWN,
    input  wire logic       ANALOG_EN,
    input  wire logic       STOP_MODE,
    input  wire logic       WAIT_MODE,
    input  wire logic       RC_TICK,
    output logic            RC_OSC_RUN,
    output logic            PORT_IRQ,
    output logic            WAKEUP
);

    // ==========================================================
    // Declarations
    gpe_cfg_s  cfg_q;
    gpe_byte_t flags_q;
    gpe_byte_t flags_d;
    gpe_byte_t pin_s;
    gpe_byte_t din;
    gpe_byte_t act;
    gpe_byte_t edges;
    gpe_byte_t drv;
    gpe_byte_t pull_on;
    gpe_byte_t clr_mask;
    gpe_byte_t rd_d;
    gpe_byte_t stat;
    logic      rc_s;
    logic      rc_prev_q;
    logic      rc_pulse;
    logic      smp;
    logic      async_hit;
    logic      wr_data;
    logic      wr_dir;
    logic      wr_rdrv;
    logic      wr_pull;
    logic      wr_pol;
    logic      wr_ien;
    logic      wr_flag;
    logic      wr_dien;

    // ==========================================================
    // Register port decode
    // Writes are single strobes, so the decode is a plain compare
    assign wr_data = WR && (ADDR == ADDR_DATA);
    assign wr_dir  = WR && (ADDR == ADDR_DIR);
    assign wr_rdrv = WR && (ADDR == ADDR_RDRV);
    assign wr_pull = WR && (ADDR == ADDR_PULLEN);
    assign wr_pol  = WR && (ADDR == ADDR_POL);
    assign wr_ien  = WR && (ADDR == ADDR_IEN);
    assign wr_flag = WR && (ADDR == ADDR_FLAG);
    assign wr_dien = WR && (ADDR == ADDR_DIEN);

    // ==========================================================
    // Configuration registers
    // Output data; stored even while the pin is an input
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q.out <= RST_ZERO; // [RL8]
        end else if (wr_data) begin
            cfg_q.out <= WDATA;
        end
    end

    // Direction; owned bits keep their value so a peripheral is not upset
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q.dir <= RST_ZERO; // [RL7] [RL8]
        end else if (wr_dir) begin
            cfg_q.dir <= (cfg_q.dir & PERIPH_OWN) | (WDATA & ~PERIPH_OWN); // [RL19]
        end
    end

    // Reduced drive select
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q.rdrv <= RST_ZERO; // [RL8]
        end else if (wr_rdrv) begin
            cfg_q.rdrv <= WDATA;
        end
    end

    // Pull device enable
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q.pull_en <= RST_ZERO; // [RL8]
        end else if (wr_pull) begin
            cfg_q.pull_en <= WDATA;
        end
    end

    // Polarity select, shared by pull choice and edge choice
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q.pol <= RST_ZERO; // [RL8]
        end else if (wr_pol) begin
            cfg_q.pol <= WDATA;
        end
    end

    // Pin interrupt enables; reset leaves every interrupt off
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q.irq_en <= RST_ZERO; // [RL7] [RL8]
        end else if (wr_ien) begin
            cfg_q.irq_en <= WDATA;
        end
    end

    // Digital input buffer enables
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            cfg_q.dien <= RST_DIEN; // [RL8]
        end else if (wr_dien) begin
            cfg_q.dien <= WDATA;
        end
    end

    // ==========================================================
    // Pad control
    // Analog ownership overrides direction for the whole port
    assign drv        = cfg_q.dir & {8{~ANALOG_EN}}; // [RL6]
    assign PIN_OE_N   = ~drv; // [RL4] [RL19]
    assign PIN_OUT    = cfg_q.out; // [RL4]
    assign PIN_RDRV   = drv & cfg_q.rdrv; // [RL4]

    // Pulls only on inputs; polarity picks the direction of the pull
    assign pull_on    = ~cfg_q.dir & cfg_q.pull_en; // [RL3]
    assign PIN_PULLUP = pull_on & ~cfg_q.pol; // [RL1] [RL3]
    assign PIN_PULLDN = pull_on & cfg_q.pol; // [RL1] [RL3]

    // ==========================================================
    // Input path
    // Pads are asynchronous, so every use except the raw stop-mode wake path goes through two flops
    gpe_sync2 #(
        .W     (NPIN)
    ) u_pin_sync (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .d     (PIN_IN),
        .q     (pin_s)
    ); // [RL23] [RL21]

    // Buffer off or analog on reads as 1; outputs always see their pad
    assign din = ANALOG_EN ? 8'hFF : (pin_s | ~(cfg_q.dien | cfg_q.dir)); // [RL6] [RL10]

    // Active level per pin: polarity 1 means rising, 0 falling
    assign act = ~(din ^ cfg_q.pol); // [RL1] [RL2]

    // ==========================================================
    // Sample clocking
    // The RC tick comes from its own oscillator and is synchronised first
    gpe_sync2 #(
        .W     (1)
    ) u_rc_sync (
        .clk   (REF_CLK),
        .rst_n (RSTN),
        .d     (RC_TICK),
        .q     (rc_s)
    );

    // Edge detect on the synchronised tick
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            rc_prev_q <= 1'b0;
        end else begin
            rc_prev_q <= rc_s;
        end
    end

    assign rc_pulse = rc_s & ~rc_prev_q;

    // Every bus clock outside stop, one sample per RC period inside it
    assign smp = !STOP_MODE || rc_pulse; // [RL15] [RL16] [RL14]

    // Oscillator runs only while an armed pin still waits for its edge
    assign RC_OSC_RUN = STOP_MODE && (|(cfg_q.irq_en & ~flags_q)); // [RL17]

    // ==========================================================
    // Per-pin filters
    // One filter per pin; all eight feed a single request line
    for (genvar i = 0; i < NPIN; i++) begin : g_pin // [RL9] [RL5]
        gpe_edge_filter u_filt (
            .clk    (REF_CLK),
            .rst_n  (RSTN),
            .smp    (smp),
            .act    (act[i]),
            .arm    (cfg_q.irq_en[i]),
            .edge_o (edges[i])
        );
    end

    // ==========================================================
    // Interrupt flags
    // Write-1-to-clear; an edge in the same cycle wins over the clear
    assign clr_mask = wr_flag ? WDATA : RST_ZERO;
    assign flags_d  = (flags_q & ~clr_mask) | edges; // [RL22]

    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            flags_q <= RST_ZERO; // [RL8]
        end else begin
            flags_q <= flags_d; // [RL22]
        end
    end

    // Shared request for the whole port
    assign PORT_IRQ = |(flags_q & cfg_q.irq_en); // [RL11] [RL5]

    // ==========================================================
    // Wake-up
    // Raw pad path: in stop the bus clock may be gone, so no flop sits here.
    // It only reports an active level; the filter still qualifies the edge.
    assign async_hit = STOP_MODE && !ANALOG_EN
                       && (|(cfg_q.irq_en & ~flags_q & ~(PIN_IN ^ cfg_q.pol))); // [RL18]

    assign WAKEUP = ((STOP_MODE || WAIT_MODE) && PORT_IRQ) || async_hit; // [RL12]

    // ==========================================================
    // Read path
    // Status gathers the port level state for polling software
    always_comb begin
        stat            = RST_ZERO;
        stat[STAT_IRQ]  = PORT_IRQ;
        stat[STAT_RC]   = RC_OSC_RUN;
        stat[STAT_WAKE] = WAKEUP;
    end

    // Data read follows direction; synchroniser delay shows as lag
    always_comb begin
        case (ADDR)
            ADDR_DATA:   rd_d = (cfg_q.dir & cfg_q.out) | (~cfg_q.dir & din); // [RL20] [RL21]
            ADDR_INPUT:  rd_d = din;
            ADDR_DIR:    rd_d = cfg_q.dir;
            ADDR_RDRV:   rd_d = cfg_q.rdrv;
            ADDR_PULLEN: rd_d = cfg_q.pull_en;
            ADDR_POL:    rd_d = cfg_q.pol;
            ADDR_IEN:    rd_d = cfg_q.irq_en;
            ADDR_FLAG:   rd_d = flags_q;
            ADDR_DIEN:   rd_d = cfg_q.dien;
            ADDR_STAT:   rd_d = stat;
            default:     rd_d = RST_ZERO;
        endcase
    end

    // Read data stands for one cycle only, zero otherwise
    always_ff @(posedge REF_CLK or negedge RSTN) begin
        if (!RSTN) begin
            RDATA <= RST_ZERO;
        end else begin
            RDATA <= RD ? rd_d : RST_ZERO;
        end
    end

    // ==========================================================
    // Checks
    default clocking cb @(posedge REF_CLK); endclocking
    default disable iff (!RSTN);

    sequence flag_clear_s;
        wr_flag && (WDATA != RST_ZERO);
    endsequence

    sequence no_edge_s;
        edges == RST_ZERO;
    endsequence

    irq_request_a: assert property ( // [RL11]
        $rose(PORT_IRQ) |-> $past((|edges) || wr_ien))
        else $error("request raised without flag or enable");

    flag_set_a: assert property ( // [RL22]
        (|edges) |=> ((flags_q & $past(edges)) == $past(edges)))
        else $error("edge did not set its flag");

    flag_clear_a: assert property ( // [RL22]
        (flag_clear_s and no_edge_s) |=> ((flags_q & $past(WDATA)) == RST_ZERO))
        else $error("write one did not clear flag");

    analog_off_a: assert property ( // [RL6]
        ANALOG_EN |-> (PIN_OE_N == 8'hFF) && (din == 8'hFF))
        else $error("digital path active under analog");

    dir_lock_a: assert property ( // [RL19]
        wr_dir |=> ((cfg_q.dir & $past(PERIPH_OWN)) == ($past(cfg_q.dir) & $past(PERIPH_OWN))))
        else $error("owned direction bit changed");

    no_out_pull_a: assert property ( // [RL3]
        ((PIN_PULLUP | PIN_PULLDN) & cfg_q.dir) == RST_ZERO)
        else $error("pull active on output pin");

    out_readback_a: assert property ( // [RL20]
        (RD && ADDR == ADDR_DATA) |=> ((RDATA & $past(cfg_q.dir)) == ($past(cfg_q.out) & $past(cfg_q.dir))))
        else $error("output readback wrong");

    rc_idle_a: assert property ( // [RL17]
        (STOP_MODE && !RC_OSC_RUN) |-> ((cfg_q.irq_en & ~flags_q) == RST_ZERO))
        else $error("rc oscillator off while pin armed");

    wake_irq_a: assert property ( // [RL12]
        (PORT_IRQ && (STOP_MODE || WAIT_MODE)) |-> WAKEUP)
        else $error("no wake-up for pending request");

    run_sample_a: assert property ( // [RL15]
        !STOP_MODE |-> smp)
        else $error("filter not sampled in run");

    read_once_a: assert property ( // [RL21]
        !RD |=> (RDATA == RST_ZERO))
        else $error("read data held past its cycle");

endmodule : gpe_port

// *** rtl/gpe_sync2.sv ***
// Purpose: Two-flop synchroniser for asynchronous inputs.
// Assumes: Inputs are quasi-static compared with the clock.
// Notes:   First stage feeds only the second stage.

`timescale 1ns/1ps

// ==========================================================
// Synchroniser
module gpe_sync2 #(
    parameter int W = 8
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);

    logic [W-1:0] meta_q;

    // Two stages; values lag the pin by two edges
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= '0;
            q      <= '0;
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end

endmodule : gpe_sync2
